//--- ovrs_pkg.sv
// overrange sticky status bank: shared constants, register map and decode helpers
// assumes a byte-wide register port with addresses up to ten bits
package ovrs_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int NUM_CONV = 24;
	localparam int CLR_BITS = 96;
	localparam int CLR_BYTES = 12;
	localparam int FLAG_BYTES = 3;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	// clear field bytes 0..11 sit at consecutive addresses
	localparam logic [ADDR_W-1:0] CLR_BASE = 10'h18d;
	localparam logic [ADDR_W-1:0] CLR_BYTE8_ADDR = 10'h195;
	localparam logic [ADDR_W-1:0] CLR_BYTE9_ADDR = 10'h196;
	localparam logic [ADDR_W-1:0] CLR_BYTE10_ADDR = 10'h197;
	localparam logic [ADDR_W-1:0] CLR_BYTE11_ADDR = 10'h198;
	localparam logic [ADDR_W-1:0] FLAG_BASE = 10'h199;
	localparam logic [ADDR_W-1:0] FLAG_BYTE1_ADDR = 10'h19a;
	localparam logic [ADDR_W-1:0] FLAG_BYTE2_ADDR = 10'h19b;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] CLR_RESET = 8'h00;
	localparam logic [DATA_W-1:0] FLAG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

	typedef enum logic [1:0] {
		OVRS_HIT_NONE,
		OVRS_HIT_CLEAR,
		OVRS_HIT_FLAG
	} ovrs_hit_t;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic ovrs_hit_t ovrs_decode(input logic [ADDR_W-1:0] addr);
		ovrs_hit_t hit;
		hit = OVRS_HIT_NONE;
		if (addr >= CLR_BASE && addr < CLR_BASE + ADDR_W'(CLR_BYTES)) begin
			hit = OVRS_HIT_CLEAR;
		end else if (addr >= FLAG_BASE && addr < FLAG_BASE + ADDR_W'(FLAG_BYTES)) begin
			hit = OVRS_HIT_FLAG;
		end
		return hit;
	endfunction

	function automatic logic [3:0] ovrs_index(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] base);
		logic [ADDR_W-1:0] diff;
		diff = addr - base;
		return diff[3:0];
	endfunction

endpackage

//--- ovrs_clear_bank.sv
// overrange sticky status bank: the 96-bit clear field held as twelve byte registers
// assumes write strobe and data come from logic on the same clock
`timescale 1ns/1ns
module ovrs_clear_bank
	import ovrs_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [3:0] wr_index_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	// clear field
	output logic [CLR_BITS-1:0] clear_vector_o
);

	logic [DATA_W-1:0] clear_reg [CLR_BYTES];

	// ----------------------------------------
	// byte registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < CLR_BYTES; i++) begin
				clear_reg[i] <= CLR_RESET; // (RL6)
			end
		end else if (wr_en_i) begin
			clear_reg[wr_index_i] <= wr_data_i; // (RL4)
		end
	end

	always_comb begin
		for (int i = 0; i < CLR_BYTES; i++) begin
			clear_vector_o[i*DATA_W +: DATA_W] = clear_reg[i]; // (RL4)
		end
	end

endmodule

//--- ovrs_sticky.sv
// overrange sticky status bank: one sticky flag per converter
// assumes overrange events come from the converter datapath on the same clock
`timescale 1ns/1ns
module ovrs_sticky
	import ovrs_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// events and clears
	input wire logic [NUM_CONV-1:0] event_i,
	input wire logic [NUM_CONV-1:0] clear_i,
	// flags
	output logic [NUM_CONV-1:0] flags_o
);

	logic [NUM_CONV-1:0] flags_reg;
	logic [NUM_CONV-1:0] flags_next;

	// clear dominates while held, so a held clear masks new events
	always_comb begin
		flags_next = (flags_reg | event_i) & ~clear_i; // (RL2) (RL3) (RL5) (RL9)
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_reg <= {NUM_CONV{1'b0}}; // (RL7)
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;

endmodule

//--- ovrs_bank.sv
// overrange sticky status bank: register port, clear field and sticky flags
// assumes the register port and the overrange events share core_clk_i
//
// Summary of operation
// (RL1) one active-high sticky flag per converter
// (RL2) overrange event sets that converter's flag
// (RL3) flag holds until its clear bit written
// (RL4) 96-bit clear field over byte registers
// (RL5) held clear bit blocks further overrange reporting
// (RL6) clear bytes read/write, reset to zero
// (RL7) flag bytes read-only, reset to zero
// (RL8) flag bytes ascending from converters 7..0
// (RL9) coincident clear wins; set only afterwards
`timescale 1ns/1ns
module ovrs_bank
	import ovrs_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// converter datapath
	input wire logic [NUM_CONV-1:0] conv_overrange_i,
	output logic [NUM_CONV-1:0] overrange_sticky_flags_o
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	ovrs_hit_t hit;
	logic [3:0] clr_idx;
	logic [3:0] flag_idx;
	logic clr_wr;
	logic [CLR_BITS-1:0] overrange_clear_vector;
	logic [NUM_CONV-1:0] overrange_sticky_flags;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic rvalid_reg;

	assign hit = ovrs_decode(reg_addr_i);
	assign clr_idx = ovrs_index(reg_addr_i, CLR_BASE);
	assign flag_idx = ovrs_index(reg_addr_i, FLAG_BASE);
	// writes to flag bytes or unmapped addresses are dropped
	assign clr_wr = reg_wr_i && (hit == OVRS_HIT_CLEAR); // (RL7)

	// ----------------------------------------
	// clear field
	// ----------------------------------------
	ovrs_clear_bank u_clear (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.wr_en_i(clr_wr),
		.wr_index_i(clr_idx),
		.wr_data_i(reg_wdata_i),
		.clear_vector_o(overrange_clear_vector)
	);

	// ----------------------------------------
	// sticky flags
	// ----------------------------------------
	// only converters 0..23 report here; clear bits above 23 are stored only
	ovrs_sticky u_sticky (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.event_i(conv_overrange_i),
		.clear_i(overrange_clear_vector[NUM_CONV-1:0]), // (RL4)
		.flags_o(overrange_sticky_flags)
	);

	assign overrange_sticky_flags_o = overrange_sticky_flags; // (RL1)

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rdata_next = UNMAPPED_READ;
		case (hit)
			OVRS_HIT_CLEAR: begin
				rdata_next = overrange_clear_vector[clr_idx*DATA_W +: DATA_W]; // (RL6)
			end
			OVRS_HIT_FLAG: begin
				rdata_next = overrange_sticky_flags[flag_idx*DATA_W +: DATA_W]; // (RL8)
			end
			default: begin
				rdata_next = UNMAPPED_READ;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= FLAG_RESET;
		end else if (reg_rd_i) begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd_i;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	logic [NUM_CONV-1:0] clr24;
	assign clr24 = overrange_clear_vector[NUM_CONV-1:0];

	// clear bits as they stood one cycle ago, to see a clear being let go
	logic [NUM_CONV-1:0] clr24_q;
	logic [NUM_CONV-1:0] released_ovr;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clr24_q <= {NUM_CONV{1'b0}};
		end else begin
			clr24_q <= clr24;
		end
	end

	assign released_ovr = clr24_q & ~clr24 & conv_overrange_i;

	sequence rd_flag_s(logic [ADDR_W-1:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence

	sequence wr_clear_s;
		reg_wr_i && (hit == OVRS_HIT_CLEAR) ##1 !reg_wr_i;
	endsequence

	flag_set_a: assert property ( // (RL2)
		(conv_overrange_i & ~clr24) != '0 |=>
		((overrange_sticky_flags & $past(conv_overrange_i & ~clr24))
		== $past(conv_overrange_i & ~clr24)))
		else $error("overrange event did not set its flag");

	flag_hold_a: assert property ( // (RL3)
		(overrange_sticky_flags & ~clr24) != '0 |=> (overrange_sticky_flags &
		$past(overrange_sticky_flags & ~clr24)) == $past(overrange_sticky_flags & ~clr24))
		else $error("sticky flag dropped without a clear");

	clear_wins_a: assert property ( // (RL9)
		clr24 != '0 |=> (overrange_sticky_flags & $past(clr24)) == '0)
		else $error("flag set while its clear bit was held");

	clear_blocks_a: assert property ( // (RL5)
		(clr24 & conv_overrange_i) != '0 ##1 (clr24 & $past(clr24)) == $past(clr24)
		|=> (overrange_sticky_flags & $past(clr24, 2)) == '0)
		else $error("held clear let an overrange through");

	clear_write_a: assert property ( // (RL6)
		wr_clear_s |-> overrange_clear_vector[$past(clr_idx, 1)*DATA_W +: DATA_W]
		== $past(reg_wdata_i, 1))
		else $error("clear byte write not stored");

	flags_ro_a: assert property ( // (RL7)
		reg_wr_i && hit == OVRS_HIT_FLAG && conv_overrange_i == '0 && clr24 == '0
		|=> $stable(overrange_sticky_flags))
		else $error("write changed the read-only flag bytes");

	read_byte0_a: assert property ( // (RL8)
		rd_flag_s(FLAG_BASE) |=> reg_rvalid_o &&
		reg_rdata_o == $past(overrange_sticky_flags[7:0]))
		else $error("flag byte 0 read mismatch");

	read_byte2_a: assert property ( // (RL1)
		rd_flag_s(FLAG_BYTE2_ADDR) |=> reg_rvalid_o &&
		reg_rdata_o == $past(overrange_sticky_flags[23:16]))
		else $error("flag byte 2 read mismatch");

	read_clear_a: assert property ( // (RL4)
		reg_rd_i && reg_addr_i == CLR_BYTE11_ADDR && !reg_wr_i
		|=> reg_rdata_o == $past(overrange_clear_vector[95:88]))
		else $error("clear byte 11 read mismatch");

	// ----------------------------------------
	// read port checks
	// ----------------------------------------
	// exactly one answer per strobe, so a polling loop never counts a stale byte twice
	sequence rd_clear_s(logic [ADDR_W-1:0] a);
		reg_rd_i && !reg_wr_i && reg_addr_i == a;
	endsequence

	sequence rd_hit_s(ovrs_hit_t h);
		reg_rd_i && hit == h;
	endsequence

	rvalid_pulse_a: assert property ( // (RL8)
		reg_rvalid_o == $past(reg_rd_i))
		else $error("read answer not one cycle after its strobe");

	rdata_hold_a: assert property ( // (RL8)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");

	read_byte1_a: assert property ( // (RL8)
		rd_flag_s(FLAG_BYTE1_ADDR) |=> reg_rvalid_o &&
		reg_rdata_o == $past(overrange_sticky_flags[15:8]))
		else $error("flag byte 1 read mismatch");

	read_clear0_a: assert property ( // (RL6)
		rd_clear_s(CLR_BASE)
		|=> reg_rdata_o == $past(overrange_clear_vector[7:0]))
		else $error("clear byte 0 read mismatch");

	read_clear8_a: assert property ( // (RL6)
		rd_clear_s(CLR_BYTE8_ADDR)
		|=> reg_rdata_o == $past(overrange_clear_vector[71:64]))
		else $error("clear byte 8 read mismatch");

	read_clear9_a: assert property ( // (RL6)
		rd_clear_s(CLR_BYTE9_ADDR)
		|=> reg_rdata_o == $past(overrange_clear_vector[79:72]))
		else $error("clear byte 9 read mismatch");

	read_clear10_a: assert property ( // (RL6)
		rd_clear_s(CLR_BYTE10_ADDR)
		|=> reg_rdata_o == $past(overrange_clear_vector[87:80]))
		else $error("clear byte 10 read mismatch");

	unmapped_read_a: assert property ( // (RL8)
		rd_hit_s(OVRS_HIT_NONE) |=> reg_rvalid_o && reg_rdata_o == UNMAPPED_READ)
		else $error("unmapped read did not return zero");

	// a read beside a write returns the byte as it stood before the write
	rd_wr_same_a: assert property ( // (RL6)
		reg_rd_i && reg_wr_i && hit == OVRS_HIT_CLEAR
		|=> reg_rdata_o == $past(overrange_clear_vector[clr_idx*DATA_W +: DATA_W]))
		else $error("read beside a write did not return the old byte");

	// ----------------------------------------
	// write path checks
	// ----------------------------------------
	// a stray clear bit would silently mask a converter until software looked
	clear_idle_a: assert property ( // (RL6)
		!reg_wr_i |=> $stable(overrange_clear_vector))
		else $error("clear field moved without a write");

	clear_byte8_a: assert property ( // (RL4)
		reg_wr_i && reg_addr_i == CLR_BYTE8_ADDR
		|=> overrange_clear_vector[71:64] == $past(reg_wdata_i))
		else $error("clear byte 8 write not stored");

	clear_byte11_a: assert property ( // (RL4)
		reg_wr_i && reg_addr_i == CLR_BYTE11_ADDR
		|=> overrange_clear_vector[95:88] == $past(reg_wdata_i))
		else $error("clear byte 11 write not stored");

	ro_keeps_clear_a: assert property ( // (RL7)
		reg_wr_i && hit != OVRS_HIT_CLEAR |=> $stable(overrange_clear_vector))
		else $error("write outside the clear bytes changed the clear field");

	// bits above the converters served here are storage only
	upper_clear_a: assert property ( // (RL4)
		reg_wr_i && hit == OVRS_HIT_CLEAR && clr_idx >= 4'(FLAG_BYTES) &&
		conv_overrange_i == '0 && clr24 == '0 |=> $stable(overrange_sticky_flags))
		else $error("upper clear byte reached the flags");

	// ----------------------------------------
	// flag cause checks
	// ----------------------------------------
	// every edge of a flag needs a cause one cycle earlier
	flag_rise_cause_a: assert property ( // (RL2)
		(overrange_sticky_flags & ~$past(overrange_sticky_flags) &
		~$past(conv_overrange_i & ~clr24)) == '0)
		else $error("flag set without an overrange event");

	flag_fall_cause_a: assert property ( // (RL3)
		($past(overrange_sticky_flags) & ~overrange_sticky_flags & ~$past(clr24)) == '0)
		else $error("flag dropped without its clear bit");

	sequence clear_released_s;
		clr24 != '0 ##1 released_ovr != '0;
	endsequence

	clear_release_a: assert property ( // (RL9)
		clear_released_s |=>
		(overrange_sticky_flags & $past(released_ovr)) == $past(released_ovr))
		else $error("event after a released clear was not reported");

	// ----------------------------------------
	// reset checks
	// ----------------------------------------
	// these must run while reset is low, so they replace the default disable
	reset_zero_a: assert property ( // (RL7)
		disable iff (1'b0)
		!reset_n_i |=> overrange_sticky_flags == '0 && overrange_clear_vector == '0 &&
		!reg_rvalid_o && reg_rdata_o == FLAG_RESET)
		else $error("state not at its reset value");

endmodule

//--- ovrs_bank_tb_top.sv
// self-checking testbench for the overrange sticky status bank
// assumes one 100 MHz clock; all inputs change at falling edges
`timescale 1ns/1ns
module ovrs_bank_tb_top
	import ovrs_pkg::*;
;
	logic clk;
	logic rst_n;
	logic [ADDR_W-1:0] addr;
	logic wr;
	logic rd;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic rvalid;
	logic [NUM_CONV-1:0] ovr;
	logic [NUM_CONV-1:0] flags;
	int miscompares = 0;
	int comparisons = 0;

	ovrs_bank u_dut (
		.core_clk_i(clk),
		.reset_n_i(rst_n),
		.reg_addr_i(addr),
		.reg_wr_i(wr),
		.reg_wdata_i(wdata),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid),
		.conv_overrange_i(ovr),
		.overrange_sticky_flags_o(flags)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	// read answer is due exactly one cycle after the strobe edge
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(24'(rvalid), 24'h1);
		chk(24'(rdata), 24'(e));
	endtask

	task automatic pulse(input int n);
		@(negedge clk);
		ovr[n] = 1'b1;
		@(negedge clk);
		ovr[n] = 1'b0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(flags, 24'h0);
		for (int i = 0; i < CLR_BYTES; i++) begin
			rd_chk(CLR_BASE + ADDR_W'(i), CLR_RESET);
		end
		for (int k = 0; k < FLAG_BYTES; k++) begin
			rd_chk(FLAG_BASE + ADDR_W'(k), FLAG_RESET);
		end
	endtask

	task automatic t_clear_rw();
		for (int i = 0; i < 4; i++) begin
			wr_reg(CLR_BYTE8_ADDR + ADDR_W'(i), 8'h5a + 8'(i * 17));
		end
		for (int i = 0; i < 4; i++) begin
			rd_chk(CLR_BYTE8_ADDR + ADDR_W'(i), 8'h5a + 8'(i * 17));
		end
		for (int i = 0; i < 4; i++) begin
			wr_reg(CLR_BYTE8_ADDR + ADDR_W'(i), 8'h00);
		end
		chk(flags, 24'h0);
	endtask

	// every converter in turn: set, hold, read its byte, clear
	task automatic t_walk();
		logic [ADDR_W-1:0] ca;
		for (int n = 0; n < NUM_CONV; n++) begin
			ca = CLR_BASE + ADDR_W'(n / 8);
			pulse(n);
			chk(flags, 24'h1 << n);
			repeat (3) @(negedge clk);
			chk(flags, 24'h1 << n);
			rd_chk(FLAG_BASE + ADDR_W'(n / 8), 8'h01 << (n % 8));
			wr_reg(ca, 8'h01 << (n % 8));
			@(negedge clk);
			chk(flags, 24'h0);
			wr_reg(ca, 8'h00);
		end
	endtask

	task automatic t_readonly();
		pulse(5);
		wr_reg(FLAG_BASE, 8'h00);
		wr_reg(FLAG_BYTE2_ADDR, 8'hff);
		rd_chk(FLAG_BASE, 8'h20);
		rd_chk(FLAG_BYTE2_ADDR, 8'h00);
		wr_reg(CLR_BASE, 8'h20);
		wr_reg(CLR_BASE, 8'h00);
	endtask

	// event held high across a held clear and its release
	task automatic t_block();
		wr_reg(CLR_BASE, 8'h04);
		@(negedge clk);
		ovr[2] = 1'b1;
		repeat (4) @(negedge clk);
		chk(flags, 24'h0);
		wr_reg(CLR_BASE, 8'h00);
		@(negedge clk);
		chk(flags, 24'h4);
		ovr[2] = 1'b0;
		repeat (2) @(negedge clk);
		chk(flags, 24'h4);
		wr_reg(CLR_BASE, 8'h04);
		wr_reg(CLR_BASE, 8'h00);
		chk(flags, 24'h0);
	endtask

	task automatic t_unmapped();
		wr_reg(10'h000, 8'hff);
		rd_chk(CLR_BASE + ADDR_W'(3), CLR_RESET);
		rd_chk(10'h000, UNMAPPED_READ);
		rd_chk(10'h19c, UNMAPPED_READ);
		rd_chk(10'h18c, UNMAPPED_READ);
	endtask

	// read and write of one clear byte in the same cycle: the read sees the old value
	task automatic t_rw_same();
		@(negedge clk);
		addr = CLR_BYTE9_ADDR;
		wdata = 8'h3c;
		wr = 1'b1;
		rd = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		chk(24'(rvalid), 24'h1);
		chk(24'(rdata), 24'(CLR_RESET));
		rd_chk(CLR_BYTE9_ADDR, 8'h3c);
		@(negedge clk);
		chk(24'(rvalid), 24'h0);
		chk(24'(rdata), 24'h3c);
		wr_reg(CLR_BYTE9_ADDR, 8'h00);
	endtask

	// reset in mid-run returns written clear bytes and set flags to zero
	task automatic t_midreset();
		wr_reg(CLR_BYTE10_ADDR, 8'ha5);
		pulse(9);
		chk(flags, 24'h200);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk(flags, 24'h0);
		rd_chk(CLR_BYTE10_ADDR, CLR_RESET);
		rd_chk(FLAG_BYTE1_ADDR, FLAG_RESET);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// whole run is under a thousand cycles; this allows a wide margin
	initial begin
		#100000;
		miscompares++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		addr = '0;
		wr = 1'b0;
		rd = 1'b0;
		wdata = '0;
		ovr = '0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_clear_rw();
		t_walk();
		t_readonly();
		t_block();
		t_unmapped();
		t_rw_same();
		t_midreset();
		finish_test();
	end
endmodule
